// File: rtl/sarcc_defines.svh
// How it works
// - Conversion starts only on select falling edge
// - Select fall wakes device, sampler goes tracking
// - Sampler holds throughout power-down
// - Master gives two clocks for wake-up, acquisition
// - Sampler returns to hold on third falling edge
// - Auto power-down on edge 16/14/12
// - 12-bit word: four zeros, result MSB first
// - Every variant: four zeros, then MSB first
// - Result is straight unsigned binary code
// - Early select rise aborts, powers down, releases
// - Serial clock steps shifting and approximation
// - Data output changes on serial clock falls
// - Select fall drives output, first zero shown
// - Each later fall but the last shifts out the next bit; the last powers down
`ifndef SARCC_DEFINES_SVH
`define SARCC_DEFINES_SVH

// ----------------------------------------------------------------
// Frame layout and timing
// ----------------------------------------------------------------
`define SARCC_RES_DEFAULT   12
`define SARCC_LEAD_ZEROS    4
`define SARCC_HOLD_EDGE     3
`define SARCC_WAKE_CLOCKS   2
`define SARCC_CNT_W         5
`define SARCC_FIFO_DEPTH    8

`endif

// File: rtl/sarcc_pkg.sv
`default_nettype none
package sarcc_pkg;
   typedef enum logic {
      SARCC_PWR_DOWN,
      SARCC_ACTIVE
   } sarcc_state_t;
endpackage : sarcc_pkg
`default_nettype wire

// File: rtl/sarcc_fifo.sv
`default_nettype none
module sarcc_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             sys_rst,
   // Filling side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Draining side
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;
   logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;
   logic [AW:0]      count_r,  count_nxt;
   logic             ovalid_r, ovalid_nxt;
   logic [WIDTH-1:0] odata_r,  odata_nxt;
   logic             push;
   logic             load;

   // Depth must be a power of two so the pointers wrap by themselves
   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign push      = in_valid && in_ready;
   assign load      = (count_r != '0) && (!ovalid_r || out_ready);
   assign out_valid = ovalid_r;
   assign out_data  = odata_r;

   always_comb begin
      wr_ptr_nxt = push ? wr_ptr_r + AW'(1) : wr_ptr_r;
      rd_ptr_nxt = load ? rd_ptr_r + AW'(1) : rd_ptr_r;
      count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(load);
      ovalid_nxt = load ? 1'b1 : (out_ready ? 1'b0 : ovalid_r);
      odata_nxt  = load ? mem[rd_ptr_r] : odata_r;
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         ovalid_r <= 1'b0;
         odata_r  <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
         ovalid_r <= ovalid_nxt;
         odata_r  <= odata_nxt;
      end
   end
endmodule : sarcc_fifo
`default_nettype wire

// File: rtl/sarcc_conv.sv
`include "sarcc_defines.svh"
`default_nettype none
module sarcc_conv #(
   parameter int RES_BITS   = `SARCC_RES_DEFAULT,
   parameter int FIFO_DEPTH = `SARCC_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                sys_rst,
   // Serial pins
   input  wire logic                conv_sel_n,
   input  wire logic                serial_clk,
   output logic                     result_serial_out,
   output logic                     result_serial_oe,
   // Input sample stream, one word per conversion
   input  wire logic [RES_BITS-1:0] sample_data,
   input  wire logic                sample_valid,
   output logic                     sample_ready,
   // Status
   output logic                     sample_track,
   output logic                     powered_up,
   output logic                     frame_done
);
   localparam logic [`SARCC_CNT_W-1:0] HOLD_EDGE =
      `SARCC_CNT_W'(`SARCC_HOLD_EDGE);
   localparam logic [`SARCC_CNT_W-1:0] LEAD =
      `SARCC_CNT_W'(`SARCC_LEAD_ZEROS);
   localparam logic [`SARCC_CNT_W-1:0] FRAME =
      `SARCC_CNT_W'(RES_BITS + `SARCC_LEAD_ZEROS);

   // ----------------------------------------------------------------
   // Trial value for one approximation step
   // ----------------------------------------------------------------
   function automatic logic [RES_BITS-1:0] sar_trial(
      input logic [RES_BITS-1:0]    approx,
      input logic [`SARCC_CNT_W-1:0] step
   );
      logic [RES_BITS-1:0] msb;
      msb = {1'b1, {(RES_BITS-1){1'b0}}};
      return approx | (msb >> step);
   endfunction : sar_trial

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic cs_s1_r, cs_s2_r, cs_prev_r;
   logic sck_s1_r, sck_s2_r, sck_prev_r;
   logic cs_fall, cs_rise, sck_fall;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cs_s1_r    <= 1'b1;
         cs_s2_r    <= 1'b1;
         cs_prev_r  <= 1'b1;
         sck_s1_r   <= 1'b0;
         sck_s2_r   <= 1'b0;
         sck_prev_r <= 1'b0;
      end else begin
         cs_s1_r    <= conv_sel_n;
         cs_s2_r    <= cs_s1_r;
         cs_prev_r  <= cs_s2_r;
         sck_s1_r   <= serial_clk;
         sck_s2_r   <= sck_s1_r;
         sck_prev_r <= sck_s2_r;
      end
   end

   assign cs_fall  = cs_prev_r && !cs_s2_r;
   assign cs_rise  = !cs_prev_r && cs_s2_r;
   assign sck_fall = sck_prev_r && !sck_s2_r;

   // ----------------------------------------------------------------
   // Sample buffer
   // ----------------------------------------------------------------
   logic [RES_BITS-1:0] fifo_data;
   logic                fifo_valid;
   logic                fifo_pop;

   sarcc_fifo #(
      .WIDTH (RES_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .in_data   (sample_data),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   sarcc_pkg::sarcc_state_t   state_r,  state_nxt;
   logic [`SARCC_CNT_W-1:0]   edge_r,   edge_nxt;
   logic [RES_BITS-1:0]       held_r,   held_nxt;
   logic [RES_BITS-1:0]       approx_r, approx_nxt;
   logic                      track_r,  track_nxt;
   logic                      dout_r,   dout_nxt;
   logic                      oe_r,     oe_nxt;
   logic                      done_r,   done_nxt;
   logic [`SARCC_CNT_W-1:0]   step;
   logic [RES_BITS-1:0]       trial;
   logic                      bit_val;

   always_comb begin
      state_nxt  = state_r;
      edge_nxt   = edge_r;
      held_nxt   = held_r;
      approx_nxt = approx_r;
      track_nxt  = track_r;
      dout_nxt   = dout_r;
      oe_nxt     = oe_r;
      done_nxt   = 1'b0;
      fifo_pop   = 1'b0;
      step       = edge_r + `SARCC_CNT_W'(1) - LEAD;
      trial      = sar_trial(approx_r, step);
      bit_val    = (held_r >= trial);
      case (state_r)
         sarcc_pkg::SARCC_PWR_DOWN: begin
            track_nxt = 1'b0;
            oe_nxt    = 1'b0;
            if (cs_fall) begin
               state_nxt  = sarcc_pkg::SARCC_ACTIVE;
               track_nxt  = 1'b1;
               edge_nxt   = '0;
               approx_nxt = '0;
               dout_nxt   = 1'b0;
               oe_nxt     = 1'b1;
            end
         end
         sarcc_pkg::SARCC_ACTIVE: begin
            if (cs_rise) begin
               // Early release abandons the frame
               state_nxt = sarcc_pkg::SARCC_PWR_DOWN;
               track_nxt = 1'b0;
               oe_nxt    = 1'b0;
            end else if (sck_fall) begin
               edge_nxt = edge_r + `SARCC_CNT_W'(1);
               if (edge_nxt == HOLD_EDGE) begin
                  track_nxt = 1'b0;
                  fifo_pop  = 1'b1;
                  // An empty buffer reuses the last held value
                  if (fifo_valid) begin
                     held_nxt = fifo_data;
                  end
               end
               if (edge_nxt == FRAME) begin
                  state_nxt = sarcc_pkg::SARCC_PWR_DOWN;
                  oe_nxt    = 1'b0;
                  done_nxt  = 1'b1;
               end else if (edge_nxt >= LEAD) begin
                  dout_nxt   = bit_val;
                  approx_nxt = bit_val ? trial : approx_r;
               end else begin
                  dout_nxt = 1'b0;
               end
            end
         end
         default: begin
            state_nxt = sarcc_pkg::SARCC_PWR_DOWN;
         end
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_r  <= sarcc_pkg::SARCC_PWR_DOWN;
         edge_r   <= '0;
         held_r   <= '0;
         approx_r <= '0;
         track_r  <= 1'b0;
         dout_r   <= 1'b0;
         oe_r     <= 1'b0;
         done_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         edge_r   <= edge_nxt;
         held_r   <= held_nxt;
         approx_r <= approx_nxt;
         track_r  <= track_nxt;
         dout_r   <= dout_nxt;
         oe_r     <= oe_nxt;
         done_r   <= done_nxt;
      end
   end

   assign result_serial_out = dout_r;
   assign result_serial_oe  = oe_r;
   assign sample_track      = track_r;
   assign powered_up        = (state_r == sarcc_pkg::SARCC_ACTIVE);
   assign frame_done        = done_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   logic active;
   assign active = (state_r == sarcc_pkg::SARCC_ACTIVE);

   sequence s_wake;
      !active && cs_fall;
   endsequence

   sequence s_edge(logic [`SARCC_CNT_W-1:0] n);
      active && !cs_rise && sck_fall && edge_r == n;
   endsequence

   a_start_on_fall: assert property (
      s_wake |=> active && result_serial_oe && !result_serial_out
                 && sample_track && edge_r == '0)
      else $error("frame start did not drive first zero");

   a_only_fall_starts: assert property (
      !active && !cs_fall |=> !active)
      else $error("conversion began without select fall");

   a_hold_power_down: assert property (
      !active |-> !sample_track && !result_serial_oe)
      else $error("tracking or driving while powered down");

   a_track_wakeup: assert property (
      s_wake ##1 (!sck_fall && !cs_rise)[*2] |-> sample_track)
      else $error("sampler not tracking after wake");

   a_hold_third: assert property (
      s_edge(HOLD_EDGE - `SARCC_CNT_W'(1)) |=> !sample_track)
      else $error("hold not taken on third falling edge");

   a_auto_down: assert property (
      s_edge(FRAME - `SARCC_CNT_W'(1))
      |=> !active && !result_serial_oe && frame_done)
      else $error("no power-down at final edge");

   a_abort_frame: assert property (
      active && cs_rise |=> !active && !result_serial_oe && !frame_done)
      else $error("early select rise did not abort");

   a_lead_zeros: assert property (
      active && edge_r < LEAD |-> !result_serial_out)
      else $error("leading bit not zero");

   a_bit_on_fall: assert property (
      active && !sck_fall |=> $stable(result_serial_out))
      else $error("data changed without serial clock fall");

   a_edge_count: assert property (
      active && !cs_rise && sck_fall |=> edge_r == $past(edge_r)
                                         + `SARCC_CNT_W'(1))
      else $error("edge counter missed a step");

   a_result_code: assert property (
      frame_done |-> approx_r == held_r)
      else $error("approximation differs from held sample");
endmodule : sarcc_conv
`default_nettype wire

// File: testbench/sarcc_master.sv
`default_nettype none
module sarcc_master (
   // Bench clock, used only to pace the pins
   input  wire logic clock,
   // Serial pins
   output var  logic conv_sel_n,
   output var  logic serial_clk,
   input  wire logic result_serial_out,
   input  wire logic result_serial_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // Link pacing: half of a 200 ns link period
   // ------------------------------------------------------------
   localparam int HALF = 4;
   logic [15:0] word;
   wire logic   data_pin = result_serial_oe ? result_serial_out : 1'bz;

   initial begin
      conv_sel_n = 1'b1;
      serial_clk = 1'b1;
      word       = 16'h0000;
   end

   task automatic pace(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : pace

   // Extra high half lets the first zero settle before its capture
   task automatic start();
      pace(1);
      conv_sel_n = 1'b0;
      word       = 16'h0000;
      pace(HALF);
   endtask : start

   // Capture at the end of the high half, far from the device's change
   task automatic clk_fall();
      pace(HALF);
      word       = {word[14:0], data_pin};
      serial_clk = 1'b0;
      pace(HALF);
      serial_clk = 1'b1;
   endtask : clk_fall

   task automatic stop();
      pace(HALF);
      conv_sel_n = 1'b1;
      pace(2 * HALF);
   endtask : stop
endmodule : sarcc_master
`default_nettype wire

// File: testbench/sarcc_conv_bench.sv
`default_nettype none
module sarcc_conv_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int FRAME = 16;
   logic        clock;
   logic        sys_rst;
   logic [11:0] sample_data;
   logic        sample_valid;
   wire logic   conv_sel_n;
   wire logic   serial_clk;
   wire logic   result_serial_out;
   wire logic   result_serial_oe;
   wire logic   sample_ready;
   wire logic   sample_track;
   wire logic   powered_up;
   wire logic   frame_done;
   int          failures = 0;
   int          n_checks = 0;
   int          n_done   = 0;
   logic [15:0] w;
   // Second variant: 8-bit result, twelve-edge frame
   logic [7:0]  s8_data;
   logic        s8_valid;
   wire logic   s8_sel_n;
   wire logic   s8_sclk;
   wire logic   s8_out;
   wire logic   s8_oe;
   wire logic   s8_up;
   // Sample word beside the word expected on the pin
   logic [27:0] rows [9] = '{
      {12'h000, 16'h0000}, {12'hfff, 16'h0fff}, {12'h800, 16'h0800},
      {12'h7ff, 16'h07ff}, {12'ha5a, 16'h0a5a}, {12'h5a5, 16'h05a5},
      {12'h001, 16'h0001}, {12'hc3c, 16'h0c3c}, {12'h123, 16'h0123}};

   sarcc_conv #(.RES_BITS(12), .FIFO_DEPTH(8)) dut (
      .clock(clock), .sys_rst(sys_rst),
      .conv_sel_n(conv_sel_n), .serial_clk(serial_clk),
      .result_serial_out(result_serial_out),
      .result_serial_oe(result_serial_oe),
      .sample_data(sample_data), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .sample_track(sample_track),
      .powered_up(powered_up), .frame_done(frame_done));

   sarcc_master m (
      .clock(clock), .conv_sel_n(conv_sel_n), .serial_clk(serial_clk),
      .result_serial_out(result_serial_out),
      .result_serial_oe(result_serial_oe));

   sarcc_conv #(.RES_BITS(8), .FIFO_DEPTH(8)) dut8 (
      .clock(clock), .sys_rst(sys_rst),
      .conv_sel_n(s8_sel_n), .serial_clk(s8_sclk),
      .result_serial_out(s8_out), .result_serial_oe(s8_oe),
      .sample_data(s8_data), .sample_valid(s8_valid),
      .sample_ready(), .sample_track(),
      .powered_up(s8_up), .frame_done());

   sarcc_master m8 (
      .clock(clock), .conv_sel_n(s8_sel_n), .serial_clk(s8_sclk),
      .result_serial_out(s8_out), .result_serial_oe(s8_oe));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   always @(posedge clock) if (frame_done === 1'b1) n_done <= n_done + 1;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic frame(input int falls);
      m.start();
      repeat (falls) m.clk_fall();
      m.stop();
   endtask : frame

   task automatic push(input logic [11:0] s);
      sample_valid = 1'b1;
      sample_data  = s;
      @(posedge clock);
      #1;
      sample_valid = 1'b0;
   endtask : push

   task automatic finish_test();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   // Whole run is near 2000 cycles
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      finish_test();
   end

   initial begin
      sys_rst      = 1'b1;
      sample_data  = 12'h000;
      sample_valid = 1'b0;
      s8_data      = 8'h00;
      s8_valid     = 1'b0;
      repeat (5) @(posedge clock);
      #1 sys_rst = 1'b0;
      check({11'h0, sample_ready, result_serial_oe, powered_up,
             frame_done, sample_track}, 16'h0010);
      repeat (2) m.clk_fall();
      check({14'h0, result_serial_oe, powered_up}, 16'h0000);
      frame(FRAME);
      check(m.word, 16'h0000);
      // Fill the buffer while the far side stalls
      for (int i = 0; i < 9; i++) begin
         sample_valid = 1'b1;
         sample_data  = rows[i][27:16];
         @(posedge clock);
         #1;
      end
      sample_valid = 1'b0;
      repeat (3) @(posedge clock);
      check({15'h0, sample_ready}, 16'h0000);
      for (int i = 0; i < 9; i++) begin
         frame(FRAME);
         check(m.word, rows[i][15:0]);
         check({14'h0, result_serial_oe, powered_up}, 16'h0000);
         check(16'(n_done), 16'(i + 2));
      end
      // Empty buffer: last held word again
      frame(FRAME);
      check(m.word, rows[8][15:0]);
      // Abort after the hold edge
      push(12'h9c6);
      m.start();
      check({14'h0, sample_track, powered_up}, 16'h0003);
      repeat (2) m.clk_fall();
      check({15'h0, sample_track}, 16'h0001);
      m.clk_fall();
      repeat (2) @(posedge clock);
      check({15'h0, sample_track}, 16'h0000);
      repeat (4) m.clk_fall();
      m.stop();
      check({9'h0, m.word[6:0]}, 16'h0004);
      check({13'h0, result_serial_oe, powered_up, sample_track},
            16'h0000);
      check(16'(n_done), 16'd11);
      // Fresh frame, then a fall after auto power-down
      push(12'h3e1);
      m.start();
      repeat (FRAME) m.clk_fall();
      w = m.word;
      m.clk_fall();
      check({14'h0, result_serial_oe, powered_up}, 16'h0000);
      m.stop();
      check(w, 16'h03e1);
      // Short variant: power-down on edge 12, not before
      s8_data  = 8'hb4;
      s8_valid = 1'b1;
      @(posedge clock);
      #1 s8_valid = 1'b0;
      m8.start();
      repeat (11) m8.clk_fall();
      check({14'h0, s8_oe, s8_up}, 16'h0003);
      m8.clk_fall();
      check(m8.word, 16'h00b4);
      check({14'h0, s8_oe, s8_up}, 16'h0000);
      m8.stop();
      finish_test();
   end
endmodule : sarcc_conv_bench
`default_nettype wire
